// File: shared/sdmc_regs.svh
// Register offsets, field positions and reset values of the segment display controller
`ifndef SDMC_REGS_SVH
`define SDMC_REGS_SVH
// ****************************************************************
// Register offsets (8-bit special function register space)
// ****************************************************************
`define SDMC_OFS_DISPLAY_CONFIGURATION 8'h95
`define SDMC_OFS_SEGMENT_PIN_ENABLE_A 8'h97
`define SDMC_OFS_BIAS_SOURCE_CONFIGURATION 8'h9C
`define SDMC_OFS_SEGMENT_MEMORY_POINTER 8'hAC
`define SDMC_OFS_SEGMENT_MEMORY_DATA 8'hAE
`define SDMC_OFS_DISPLAY_UPDATE_CONTROL 8'hB1
`define SDMC_OFS_SEGMENT_PIN_ENABLE_B 8'hED
// ****************************************************************
// Field positions
// ****************************************************************
`define SDMC_PTR_WRITE_BIT 7
`define SDMC_PTR_ADDR_MSB 5
`define SDMC_CON_DISPLAY_ON_BIT 7
`define SDMC_CON_SLEEP_OFF_BIT 6
`define SDMC_CON_MEM_CLEAR_BIT 5
`define SDMC_CON_MUX_MSB 1
`define SDMC_CONX_EXT_LADDER_BIT 7
`define SDMC_CONX_LEVEL_MSB 5
`define SDMC_CONY_FREEZE_BIT 0
`define SDMC_MUX_FOUR_WAY 2'h3
`define SDMC_MUX_THREE_WAY 2'h2
// ****************************************************************
// Memory size and reset values
// ****************************************************************
`define SDMC_MEM_DEPTH 15
`define SDMC_MEM_LAST 6'h0E
`define SDMC_RESET_BYTE 8'h00
`define SDMC_SEGE_A_MASK 8'hFC
`define SDMC_SEGE_B_MASK 8'h0F
`define SDMC_PTR_MASK 8'hBF
`endif

// File: shared/sdmc_pkg.sv
// Types shared by the segment display controller files
package sdmc_pkg;
	typedef logic [7:0] sdmc_byte_t;
	// Register-side access from the processor core
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sdmc_sfr_req_s;
	// Drive settings towards the glass and the analog front end
	typedef struct packed {
		logic displayActive;
		logic pumpOn;
		logic extLadder;
		logic [5:0] contrastLevel;
		logic [1:0] muxSelect;
	} sdmc_drive_cfg_s;
endpackage

// File: hw/sdmc_seg_memory.sv
// Fifteen-byte segment state memory with a latched display copy
`timescale 1ns/1ps
`include "sdmc_regs.svh"
module sdmc_seg_memory #(
	parameter int DEPTH = `SDMC_MEM_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Access port
	input wire logic wrEn,
	input wire logic clearAll,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// Display latch control
	input wire logic freeze,
	output logic [8*DEPTH-1:0] shownBits
);
	logic [7:0] mem_r [DEPTH];
	logic [8*DEPTH-1:0] shown_r;
	wire inRange = addr < 6'(DEPTH);
	assign rdata = inRange ? mem_r[addr[3:0]] : `SDMC_RESET_BYTE;
	assign shownBits = shown_r;

	always_ff @(posedge clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (srst || clearAll) begin
				mem_r[i] <= `SDMC_RESET_BYTE;
			end else if (wrEn && inRange && addr[3:0] == 4'(i)) begin
				mem_r[i] <= wdata;
			end
		end
	end

	// Display copy follows the memory only while not frozen
	always_ff @(posedge clk) begin
		if (srst) begin
			shown_r <= '0;
		end else if (!freeze) begin
			for (int i = 0; i < DEPTH; i++) begin
				shown_r[8*i +: 8] <= mem_r[i];
			end
		end
	end

	AST_FROZEN_HOLD: assert property (@(posedge clk) disable iff (srst)
		freeze |=> $stable(shownBits))
		else $error("display copy changed while frozen");
	AST_RANGE_GUARD: assert property (@(posedge clk) disable iff (srst)
		(!inRange && !clearAll) |=> $stable(mem_r[0]))
		else $error("out of range access altered memory");
endmodule

// File: hw/sdmc_top.sv
// Segment display controller: register file, pointer transfers, pin roles
`timescale 1ns/1ps
`include "sdmc_regs.svh"
// Overview of operation
// - Fifteen-byte segment memory at addresses zero to fourteen.
// - Low nibble even segment, high nibble odd; bit k is common line k.
// - Memory contents kept in low power mode two.
// - Pointer write selects a byte and starts one transfer.
// - Pointer write with bit 7 set stores data register into memory.
// - Pointer write with bit 7 clear loads memory byte into data register.
// - Freeze bit holds displayed states; clearing it applies new contents.
// - Ladder select resets to charge pump; one selects external ladder.
// - Charge pump with display disabled turns voltage generation off.
// - Six-bit contrast level gives 64 bias levels.
// - External ladder makes contrast level ineffective.
// - In mode two display on only when sleep-off 0 and enable 1.
// - Display off leaves configuration and memory untouched.
// - Segment lines 0 to 15 are always segment outputs.
// - Four-way multiplex makes shared pins common lines two and three.
// - Memory-clear bit and reset zero every memory byte.
// - Multiplex value 3 turns segment 28 and 27 pins into commons.
// - Enables for segments 16 to 25 reset to 0, 1 gives segment use.
// - Pointer: write bit 7, reserved bit 6, address 5:0, reset zero.
module sdmc_top #(
	parameter int DEPTH = `SDMC_MEM_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Special function register access
	input wire sdmc_pkg::sdmc_sfr_req_s sfrReq,
	output logic [7:0] sfrRdata,
	output logic sfrHit,
	// Power mode from the core
	input wire logic lowPowerModeTwo,
	// Glass side
	output logic [8*DEPTH-1:0] segmentStates,
	output sdmc_pkg::sdmc_drive_cfg_s driveCfg,
	output logic [28:0] segmentLineEnable,
	output logic [3:0] backplaneLineEnable
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [7:0] displayConfiguration_r;
	logic [7:0] segmentPinEnableA_r;
	logic [7:0] segmentPinEnableB_r;
	logic [7:0] biasSourceConfiguration_r;
	logic [7:0] segmentMemoryPointer_r;
	logic [7:0] segmentMemoryData_r;
	logic [7:0] displayUpdateControl_r;
	logic [7:0] memRdata;
	logic [7:0] sfrRdata_nxt;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	wire wr = sfrReq.wrEn;
	wire [7:0] a = sfrReq.addr;
	wire selCon = a == `SDMC_OFS_DISPLAY_CONFIGURATION;
	wire selSegA = a == `SDMC_OFS_SEGMENT_PIN_ENABLE_A;
	wire selConx = a == `SDMC_OFS_BIAS_SOURCE_CONFIGURATION;
	wire selPtr = a == `SDMC_OFS_SEGMENT_MEMORY_POINTER;
	wire selDat = a == `SDMC_OFS_SEGMENT_MEMORY_DATA;
	wire selCony = a == `SDMC_OFS_DISPLAY_UPDATE_CONTROL;
	wire selSegB = a == `SDMC_OFS_SEGMENT_PIN_ENABLE_B;
	wire anySel = selCon | selSegA | selConx | selPtr | selDat | selCony
		| selSegB;
	assign sfrHit = (sfrReq.wrEn | sfrReq.rdEn) & anySel;

	wire ptrWrite = wr & selPtr;
	wire ptrWriteBit = sfrReq.wdata[`SDMC_PTR_WRITE_BIT];
	wire [5:0] ptrAddr = sfrReq.wdata[`SDMC_PTR_ADDR_MSB:0];
	// Clear pulse is self-clearing so the bit never latches a reset
	wire memClear = wr & selCon & sfrReq.wdata[`SDMC_CON_MEM_CLEAR_BIT];

	// ****************************************************************
	// Segment memory
	// ****************************************************************
	// Memory has no power-mode input: mode two never touches it
	sdmc_seg_memory #(.DEPTH(DEPTH)) uMem (
		.clk(clk),
		.srst(srst),
		.wrEn(ptrWrite & ptrWriteBit),
		.clearAll(memClear),
		.addr(ptrAddr),
		.wdata(segmentMemoryData_r),
		.rdata(memRdata),
		.freeze(displayUpdateControl_r[`SDMC_CONY_FREEZE_BIT]),
		.shownBits(segmentStates)
	);

	// ****************************************************************
	// Register writes
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			displayConfiguration_r <= `SDMC_RESET_BYTE;
			biasSourceConfiguration_r <= `SDMC_RESET_BYTE;
			displayUpdateControl_r <= `SDMC_RESET_BYTE;
		end else if (wr) begin
			if (selCon) begin
				displayConfiguration_r <= sfrReq.wdata
					& ~(8'h01 << `SDMC_CON_MEM_CLEAR_BIT);
			end
			if (selConx) begin
				biasSourceConfiguration_r <= sfrReq.wdata;
			end
			if (selCony) begin
				displayUpdateControl_r <= sfrReq.wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			segmentPinEnableA_r <= `SDMC_RESET_BYTE;
			segmentPinEnableB_r <= `SDMC_RESET_BYTE;
		end else if (wr && selSegA) begin
			segmentPinEnableA_r <= sfrReq.wdata & `SDMC_SEGE_A_MASK;
		end else if (wr && selSegB) begin
			segmentPinEnableB_r <= sfrReq.wdata & `SDMC_SEGE_B_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			segmentMemoryPointer_r <= `SDMC_RESET_BYTE;
		end else if (ptrWrite) begin
			segmentMemoryPointer_r <= sfrReq.wdata & `SDMC_PTR_MASK;
		end
	end

	// Pointer read transfer overrides a same-cycle data write
	always_ff @(posedge clk) begin
		if (srst) begin
			segmentMemoryData_r <= `SDMC_RESET_BYTE;
		end else if (ptrWrite && !ptrWriteBit) begin
			segmentMemoryData_r <= memRdata;
		end else if (wr && selDat) begin
			segmentMemoryData_r <= sfrReq.wdata;
		end
	end

	// ****************************************************************
	// Register reads
	// ****************************************************************
	always_comb begin
		sfrRdata_nxt = 8'h00;
		if (selCon) sfrRdata_nxt = displayConfiguration_r;
		if (selSegA) sfrRdata_nxt = segmentPinEnableA_r;
		if (selConx) sfrRdata_nxt = biasSourceConfiguration_r;
		if (selPtr) sfrRdata_nxt = segmentMemoryPointer_r;
		if (selDat) sfrRdata_nxt = segmentMemoryData_r;
		if (selCony) sfrRdata_nxt = displayUpdateControl_r;
		if (selSegB) sfrRdata_nxt = segmentPinEnableB_r;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			sfrRdata <= 8'h00;
		end else if (sfrReq.rdEn) begin
			sfrRdata <= sfrRdata_nxt;
		end
	end

	// ****************************************************************
	// Display power and bias
	// ****************************************************************
	wire dispOnBit = displayConfiguration_r[`SDMC_CON_DISPLAY_ON_BIT];
	wire sleepOff = displayConfiguration_r[`SDMC_CON_SLEEP_OFF_BIT];
	wire extLadder = biasSourceConfiguration_r[`SDMC_CONX_EXT_LADDER_BIT];
	wire [1:0] muxSel = displayConfiguration_r[`SDMC_CON_MUX_MSB:0];
	// Only the drive is gated; registers and memory are never touched
	wire displayActive = lowPowerModeTwo ? (!sleepOff && dispOnBit)
		: dispOnBit;
	wire fourWay = muxSel == `SDMC_MUX_FOUR_WAY;
	wire threeUp = fourWay || muxSel == `SDMC_MUX_THREE_WAY;

	always_ff @(posedge clk) begin
		if (srst) begin
			driveCfg <= '0;
		end else begin
			driveCfg.displayActive <= displayActive;
			driveCfg.pumpOn <= displayActive && !extLadder;
			driveCfg.extLadder <= extLadder;
			// Ladder has no on-chip compensation, so level is masked
			driveCfg.contrastLevel <= extLadder ? 6'h00
				: biasSourceConfiguration_r[`SDMC_CONX_LEVEL_MSB:0];
			driveCfg.muxSelect <= muxSel;
		end
	end

	// ****************************************************************
	// Pin roles
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			segmentLineEnable <= {2'b11, 1'b1, 10'h000, 16'hFFFF};
			backplaneLineEnable <= 4'h3;
		end else begin
			segmentLineEnable[15:0] <= 16'hFFFF;
			segmentLineEnable[19:16] <= segmentPinEnableB_r[3:0];
			segmentLineEnable[25:20] <= segmentPinEnableA_r[7:2];
			segmentLineEnable[26] <= 1'b1;
			segmentLineEnable[27] <= !fourWay;
			segmentLineEnable[28] <= !threeUp;
			backplaneLineEnable <= {fourWay, threeUp, 2'b11};
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence ptrReadSeq;
		ptrWrite && !ptrWriteBit && ptrAddr > `SDMC_MEM_LAST;
	endsequence
	AST_READ_OUT_RANGE: assert property (@(posedge clk) disable iff (srst)
		ptrReadSeq |=> segmentMemoryData_r == 8'h00)
		else $error("out of range read did not load zero");
	AST_READ_LOAD: assert property (@(posedge clk) disable iff (srst)
		(ptrWrite && !ptrWriteBit) |=> segmentMemoryData_r == $past(memRdata))
		else $error("pointer read did not load data");
	AST_PUMP_OFF: assert property (@(posedge clk) disable iff (srst)
		(!displayActive && !extLadder) |=> !driveCfg.pumpOn)
		else $error("pump stayed on with display off");
	AST_SLEEP_OFF: assert property (@(posedge clk) disable iff (srst)
		(lowPowerModeTwo && sleepOff) |=> !driveCfg.displayActive)
		else $error("display on in mode two with sleep-off set");
	AST_LADDER_LEVEL: assert property (@(posedge clk) disable iff (srst)
		extLadder |=> driveCfg.contrastLevel == 6'h00)
		else $error("contrast applied with external ladder");
	AST_FOUR_WAY: assert property (@(posedge clk) disable iff (srst)
		fourWay |=> (backplaneLineEnable == 4'hF
		&& segmentLineEnable[28:27] == 2'b00))
		else $error("four-way pins not common lines");
	AST_LOW_SEGMENTS: assert property (@(posedge clk) disable iff (srst)
		segmentLineEnable[15:0] == 16'hFFFF)
		else $error("dedicated segment line disabled");
	AST_PTR_RESERVED: assert property (@(posedge clk) disable iff (srst)
		segmentMemoryPointer_r[6] == 1'b0)
		else $error("reserved pointer bit set");
endmodule

// File: bench/sdmc_glass_model.sv
// Behavioural glass that counts the dots it would light
`timescale 1ns/1ps
module sdmc_glass_model (
	// Drive from the controller
	input wire logic [119:0] segmentStates,
	input wire sdmc_pkg::sdmc_drive_cfg_s driveCfg,
	input wire logic [3:0] backplaneLineEnable,
	// Observed picture
	output logic [7:0] litCount
);
	// A dot lights only while its common line is in use
	always_comb begin
		litCount = 8'h00;
		for (int j = 0; j < 120; j++) begin
			if (driveCfg.displayActive && backplaneLineEnable[j % 4]
				&& segmentStates[j]) begin
				litCount = litCount + 8'h01;
			end
		end
	end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the segment display controller
`timescale 1ns/1ps
module testbench;
	// ****************************************************************
	// Signals and models
	// ****************************************************************
	logic clk, srst, lpm, act, hit, hitSeen;
	logic [119:0] sh;
	sdmc_pkg::sdmc_sfr_req_s sfrReq;
	sdmc_pkg::sdmc_drive_cfg_s driveCfg;
	logic [7:0] sfrRdata, litCount, v, a, b, rd, con;
	logic [119:0] segmentStates;
	logic [28:0] segmentLineEnable;
	logic [3:0] backplaneLineEnable, bp;
	logic [7:0] mem [15];
	logic [7:0] ofs [8] = '{8'h95, 8'h97, 8'h9C, 8'hAC, 8'hAE, 8'hB1,
		8'hED, 8'h40};
	int errTotal, checksDone, lit;
	sdmc_top dut (.clk(clk), .srst(srst), .sfrReq(sfrReq),
		.sfrRdata(sfrRdata), .sfrHit(hit), .lowPowerModeTwo(lpm),
		.segmentStates(segmentStates), .driveCfg(driveCfg),
		.segmentLineEnable(segmentLineEnable),
		.backplaneLineEnable(backplaneLineEnable));
	sdmc_glass_model glass (.segmentStates(segmentStates),
		.driveCfg(driveCfg), .backplaneLineEnable(backplaneLineEnable),
		.litCount(litCount));
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(string name, logic [119:0] exp, logic [119:0] got);
		checksDone++;
		if (exp !== got) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One idle cycle after each strobe keeps drivers from colliding
	task automatic wr(logic [7:0] ad, logic [7:0] d);
		sfrReq <= '{1'b1, 1'b0, ad, d};
		@(posedge clk);
		sfrReq <= '0;
		@(posedge clk);
	endtask
	task automatic rdReg(logic [7:0] ad, output logic [7:0] d);
		sfrReq <= '{1'b0, 1'b1, ad, 8'h00};
		@(posedge clk);
		hitSeen = hit;
		sfrReq <= '0;
		@(posedge clk);
		d = sfrRdata;
	endtask
	task automatic memRd(logic [7:0] ad, output logic [7:0] d);
		wr(8'hAC, ad);
		rdReg(8'hAE, d);
	endtask
	function automatic logic [119:0] shown();
		for (int n = 0; n < 15; n++) begin
			shown[8*n +: 8] = mem[n];
		end
	endfunction
	task automatic results();
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ****************************************************************
	// Clock, watchdog and sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errTotal++;
		results();
	end
	initial begin
		srst = 1'b1;
		lpm = 1'b0;
		sfrReq = '0;
		void'($urandom(32'h8a470c70));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rdReg(ofs[i], rd);
			chk("reg reset", 8'h00, rd);
			chk("hit", (i < 7) ? 1'b1 : 1'b0, hitSeen);
		end
		chk("pins reset", 29'h1C00FFFF, segmentLineEnable);
		chk("commons reset", 4'h3, backplaneLineEnable);
		chk("drive reset", '0, driveCfg);
		chk("shown reset", '0, segmentStates);
		$display("test reset done");
		wr(8'hB1, 8'h01);
		for (int i = 0; i < 15; i++) begin
			mem[i] = 8'($urandom);
			wr(8'hAE, mem[i]);
			wr(8'hAC, 8'h80 | 8'(i));
		end
		wr(8'hAE, 8'hA5);
		wr(8'hAC, 8'h8F);
		wr(8'hAC, 8'hBF);
		chk("frozen", '0, segmentStates);
		wr(8'hB1, 8'h00);
		repeat (2) @(posedge clk);
		chk("shown", shown(), segmentStates);
		for (int i = 0; i < 16; i++) begin
			memRd(8'(i), rd);
			chk("mem read", (i < 15) ? mem[i] : 8'h00, rd);
		end
		rdReg(8'hAC, rd);
		chk("pointer", 8'h0F, rd);
		wr(8'hAC, 8'h4E);
		rdReg(8'hAC, rd);
		chk("pointer reserved", 8'h0E, rd);
		rdReg(8'hAE, rd);
		chk("data", mem[14], rd);
		$display("test memory done");
		for (int m = 0; m < 16; m++) begin
			v = 8'($urandom);
			a = 8'($urandom);
			b = 8'($urandom);
			con = {m[0], m[1], 4'h0, m[3:2]};
			wr(8'h97, a);
			wr(8'hED, b);
			wr(8'h9C, {m[2], 1'b0, v[5:0]});
			wr(8'h95, con);
			lpm <= v[7];
			repeat (2) @(posedge clk);
			act = v[7] ? (m[0] & !m[1]) : m[0];
			chk("drive", {act, act & !m[2], m[2], m[2] ? 6'h00 : v[5:0],
				2'(m[3:2])}, driveCfg);
			chk("pins", {m[3:2] < 2, m[3:2] != 3, 1'b1, a[7:2], b[3:0],
				16'hFFFF}, segmentLineEnable);
			bp = (m[3:2] == 3) ? 4'hF : (m[3:2] == 2) ? 4'h7 : 4'h3;
			chk("commons", bp, backplaneLineEnable);
			chk("kept", shown(), segmentStates);
			lit = 0;
			sh = shown();
			for (int j = 0; j < 120; j++) begin
				lit += act && bp[j % 4] && sh[j];
			end
			chk("lit", 8'(lit), litCount);
			rdReg(8'h97, rd);
			chk("enable a", a & 8'hFC, rd);
			rdReg(8'hED, rd);
			chk("enable b", b & 8'h0F, rd);
			rdReg(8'h95, rd);
			chk("config", con, rd);
		end
		lpm <= 1'b0;
		$display("test display done");
		wr(8'h95, 8'h20);
		for (int i = 0; i < 15; i++) begin
			mem[i] = 8'h00;
		end
		repeat (2) @(posedge clk);
		chk("cleared", shown(), segmentStates);
		memRd(8'h03, rd);
		chk("cleared read", 8'h00, rd);
		rdReg(8'h95, rd);
		chk("clear bit", 8'h00, rd);
		$display("test clear done");
		results();
	end
endmodule
